// file: src/hwc_cfg.svh
// offsets, field positions, pin numbers and timing counts of the host control block
`ifndef HWC_CFG_SVH
`define HWC_CFG_SVH
`define HWC_CLK_PERIOD_NS 50
`define HWC_RST_MIN_NS 100000
`define HWC_RST_MIN_CYC ((`HWC_RST_MIN_NS + `HWC_CLK_PERIOD_NS - 1) / `HWC_CLK_PERIOD_NS)
`define HWC_WAKE_CYC 16
`define HWC_CAL_CYC 64
`define HWC_OFF_IRQ_STAT 8'h00
`define HWC_OFF_IRQ_EN 8'h04
`define HWC_OFF_SLEEP 8'h08
`define HWC_OFF_SLP_TMO 8'h0C
`define HWC_OFF_STATE 8'h10
`define HWC_OFF_RF_MODE 8'h14
`define HWC_OFF_RFSW_EN 8'h18
`define HWC_OFF_RFSW_POL 8'h1C
`define HWC_OFF_FW_DATA 8'h20
`define HWC_OFF_FW_CTRL 8'h24
`define HWC_SLP_GO_BIT 0
`define HWC_SLP_NSS_BIT 1
`define HWC_SLP_TMR_BIT 2
`define HWC_FW_START_BIT 0
`define HWC_FW_DONE_BIT 1
`define HWC_STATE_BUSY_BIT 4
`define HWC_STATE_FWOK_BIT 5
`define HWC_POL_STRIDE 8
`define HWC_PIN_BUSY 0
`define HWC_PIN_NSS 1
`define HWC_PIN_SCK 2
`define HWC_PIN_MOSI 3
`define HWC_PIN_MISO 4
`define HWC_PIN_IRQ 9
`define HWC_PIN_SPARE 11
// arbitrary value, stands for the genuine image signature
`define HWC_FW_KEY 32'h5A3C_96E1
`endif

// file: src/hwc_irq.sv
// sticky interrupt flags with write-one-to-clear and enable gating
module hwc_irq #(parameter int N = 24) (
    input wire logic hclk,
    input wire logic hresetn,
    hwc_irq_if.irq bus
);
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] en;
        logic req;
    } hwc_irq_st_t;
    hwc_irq_st_t s_r;
    hwc_irq_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (bus.clr_we) begin
            s_nxt.status = s_r.status & ~bus.wdata;
        end
        // a new event beats a clear in the same cycle
        s_nxt.status = s_nxt.status | bus.evt;
        if (bus.en_we) begin
            s_nxt.en = bus.wdata;
        end
        if (bus.flush) begin
            s_nxt.status = '0;
            s_nxt.en = '0;
        end
        s_nxt.req = |(s_nxt.status & s_nxt.en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.status = s_r.status;
    assign bus.status_nxt = s_nxt.status;
    assign bus.en_nxt = s_nxt.en;
    assign bus.req = s_r.req;

    w1c_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bus.clr_we |=> ((s_r.status & $past(bus.wdata) & ~$past(bus.evt)) == '0))
        else $error("written one did not clear its status bit");
    flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!bus.clr_we && !bus.flush) |=> ((s_r.status & $past(s_r.status)) == $past(s_r.status)))
        else $error("status bit dropped without a clear");
    req_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (s_r.req == |($past(bus.en_nxt) & s_r.status)))
        else $error("request line disagrees with enabled flags");
endmodule

// file: src/hwc_irq_if.sv
// link between the control core and the interrupt status block
interface hwc_irq_if #(parameter int N = 24) ();
    logic [N-1:0] evt;
    logic clr_we;
    logic en_we;
    logic [N-1:0] wdata;
    logic flush;
    logic [N-1:0] status;
    logic [N-1:0] status_nxt;
    logic [N-1:0] en_nxt;
    logic req;
    modport core (output evt, clr_we, en_we, wdata, flush, input status, status_nxt, en_nxt, req);
    modport irq (input evt, clr_we, en_we, wdata, flush, output status, status_nxt, en_nxt, req);
endinterface

// file: src/hwc_pkg.sv
// shared types of the host control block
package hwc_pkg;
    typedef enum logic [3:0] {
        ST_CALIB = 4'b0001,
        ST_READY = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_WAKE = 4'b1000
    } hwc_state_t;
endpackage

// file: src/hwc_rfsw_lane.sv
// one rf switch control output with a level per radio mode
module hwc_rfsw_lane #(
    parameter int MODES = 4,
    parameter int MW = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic en,
    input wire logic [MODES-1:0] pol,
    input wire logic [MW-1:0] mode,
    output logic pin_o,
    output logic pin_oe
);
    typedef struct packed {
        logic o;
        logic oe;
    } hwc_lane_st_t;
    hwc_lane_st_t s_r;
    hwc_lane_st_t s_nxt;

    always_comb begin
        s_nxt.oe = en;
        s_nxt.o = en & pol[mode];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_o = s_r.o;
    assign pin_oe = s_r.oe;

    hiz_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !en |=> !pin_oe && !pin_o)
        else $error("unassigned switch pin is driven");
    mode_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        en |=> pin_oe && (pin_o == $past(pol[mode])))
        else $error("switch level does not follow the mode polarity");
endmodule

// file: src/hwc_top.sv
// host wake, restart, pin map, rf switch and interrupt control with an AHB-Lite slave
// Behaviour
// - select falling edge ends sleep
// - sleep timer timeout also ends sleep
// - twelve pins with a fixed function map
// - up to five rf switch outputs
// - switch level configurable per radio mode
// - switches unassigned and high-z after reset
// - restart pin pulse restarts and recalibrates
// - twenty-four interrupt event sources
// - maskable sources drive the request pin
// - 24-bit status, write one clears bit
// - firmware image runs only when authenticated
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`include "hwc_cfg.svh"

module hwc_top #(
    parameter int N_PIN = 12,
    parameter int N_RF = 5,
    parameter int MODES = 4,
    parameter int MW = 2,
    parameter int N_IRQ = 24,
    parameter int CAL_CYC = `HWC_CAL_CYC,
    parameter int WAKE_CYC = `HWC_WAKE_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [N_PIN-1:0] mfp_i,
    output logic [N_PIN-1:0] mfp_o,
    output logic [N_PIN-1:0] mfp_oe,
    input wire logic hard_restart_n,
    input wire logic [N_IRQ-1:0] irq_evt,
    input wire logic miso_data,
    output logic fw_exec_ok
);
    localparam logic [11:0] RST_MIN = 12'(`HWC_RST_MIN_CYC);
    localparam logic [31:0] CAL_LAST = 32'(CAL_CYC - 1);
    localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYC - 1);
    localparam int RF_PIN [5] = '{5, 6, 7, 8, 10};

    typedef struct packed {
        hwc_pkg::hwc_state_t state;
        logic [31:0] cnt;
        logic [11:0] rst_cnt;
        logic rst_q;
        logic nss_q;
        logic wake_nss;
        logic wake_tmr;
        logic [31:0] tmo;
        logic [MW-1:0] rf_mode;
        logic [N_RF-1:0] rfsw_en;
        logic [MODES-1:0][N_RF-1:0] rfsw_pol;
        logic [31:0] fw_acc;
        logic fw_ok;
        logic busy;
        logic miso;
        logic miso_oe;
        logic irq;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic rdy;
    } hwc_top_st_t;

    localparam hwc_top_st_t TOP_RST = '{
        state: hwc_pkg::ST_CALIB,
        cnt: 32'h0000_0000,
        rst_cnt: 12'h000,
        rst_q: 1'b1,
        nss_q: 1'b1,
        wake_nss: 1'b0,
        wake_tmr: 1'b0,
        tmo: 32'h0000_0000,
        rf_mode: '0,
        rfsw_en: '0,
        rfsw_pol: '0,
        fw_acc: 32'h0000_0000,
        fw_ok: 1'b0,
        busy: 1'b1,
        miso: 1'b0,
        miso_oe: 1'b0,
        irq: 1'b0,
        a_valid: 1'b0,
        a_write: 1'b0,
        a_addr: 8'h00,
        hrdata: 32'h0000_0000,
        rdy: 1'b1
    };

    hwc_top_st_t s;
    hwc_top_st_t n;
    logic wr;
    logic restart;
    logic nss_fall;
    logic tmr_due;
    logic sleep_go;
    // an image check that finishes in the restart cycle still counts
    logic keep_ok;
    logic [31:0] keep_acc;
    logic [N_RF-1:0] rf_o;
    logic [N_RF-1:0] rf_oe;

    hwc_irq_if #(.N(N_IRQ)) ir ();

    hwc_irq #(.N(N_IRQ)) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(ir)
    );

    // data phase of a write: registers take hwdata one cycle after the address
    assign wr = s.a_valid && s.a_write;
    assign ir.evt = irq_evt;
    assign ir.wdata = hwdata[N_IRQ-1:0];
    assign ir.clr_we = wr && (s.a_addr == `HWC_OFF_IRQ_STAT);
    assign ir.en_we = wr && (s.a_addr == `HWC_OFF_IRQ_EN);
    assign ir.flush = restart;
    assign sleep_go = wr && (s.a_addr == `HWC_OFF_SLEEP) && hwdata[`HWC_SLP_GO_BIT];

    // a restart counts only once the pin has been low for more than the minimum
    assign restart = hard_restart_n && !s.rst_q && (s.rst_cnt > RST_MIN);
    assign nss_fall = s.nss_q && !mfp_i[`HWC_PIN_NSS];
    assign tmr_due = s.cnt >= s.tmo;

    genvar gi;
    generate
        for (gi = 0; gi < N_RF; gi++) begin : g_rf
            logic [MODES-1:0] lane_pol;
            for (genvar gm = 0; gm < MODES; gm++) begin : g_m
                assign lane_pol[gm] = s.rfsw_pol[gm][gi];
            end
            hwc_rfsw_lane #(.MODES(MODES), .MW(MW)) u_lane (
                .hclk(hclk),
                .hresetn(hresetn),
                .en(s.rfsw_en[gi]),
                .pol(lane_pol),
                .mode(s.rf_mode),
                .pin_o(rf_o[gi]),
                .pin_oe(rf_oe[gi])
            );
        end
    endgenerate

    always_comb begin
        n = s;
        n.nss_q = mfp_i[`HWC_PIN_NSS];
        n.rst_q = hard_restart_n;
        if (!hard_restart_n) begin
            if (s.rst_cnt != 12'hFFF) begin
                n.rst_cnt = s.rst_cnt + 12'h001;
            end
        end else begin
            n.rst_cnt = 12'h000;
        end

        if (wr) begin
            case (s.a_addr)
                `HWC_OFF_SLEEP: begin
                    n.wake_nss = hwdata[`HWC_SLP_NSS_BIT];
                    n.wake_tmr = hwdata[`HWC_SLP_TMR_BIT];
                end
                `HWC_OFF_SLP_TMO: n.tmo = hwdata;
                `HWC_OFF_RF_MODE: n.rf_mode = hwdata[MW-1:0];
                `HWC_OFF_RFSW_EN: n.rfsw_en = hwdata[N_RF-1:0];
                `HWC_OFF_RFSW_POL: begin
                    for (int m = 0; m < MODES; m++) begin
                        n.rfsw_pol[m] = hwdata[m*`HWC_POL_STRIDE +: N_RF];
                    end
                end
                `HWC_OFF_FW_DATA: n.fw_acc = {s.fw_acc[30:0], s.fw_acc[31]} ^ hwdata;
                `HWC_OFF_FW_CTRL: begin
                    // a new image revokes execution until it is checked
                    if (hwdata[`HWC_FW_START_BIT]) begin
                        n.fw_acc = 32'h0000_0000;
                        n.fw_ok = 1'b0;
                    end else if (hwdata[`HWC_FW_DONE_BIT]) begin
                        n.fw_ok = (s.fw_acc == `HWC_FW_KEY);
                    end
                end
                default: ;
            endcase
        end

        case (s.state)
            hwc_pkg::ST_CALIB: begin
                if (s.cnt >= CAL_LAST) begin
                    n.state = hwc_pkg::ST_READY;
                    n.cnt = 32'h0000_0000;
                end else begin
                    n.cnt = s.cnt + 32'h0000_0001;
                end
            end
            hwc_pkg::ST_READY: begin
                if (sleep_go) begin
                    n.state = hwc_pkg::ST_SLEEP;
                    n.cnt = 32'h0000_0000;
                end
            end
            hwc_pkg::ST_SLEEP: begin
                // with both wake sources off only a restart ends sleep
                if (s.wake_nss && nss_fall) begin
                    n.state = hwc_pkg::ST_WAKE;
                    n.cnt = 32'h0000_0000;
                end else if (s.wake_tmr && tmr_due) begin
                    n.state = hwc_pkg::ST_WAKE;
                    n.cnt = 32'h0000_0000;
                end else begin
                    n.cnt = s.cnt + 32'h0000_0001;
                end
            end
            hwc_pkg::ST_WAKE: begin
                // the wake delay starts only after the host lets select go high
                if (!mfp_i[`HWC_PIN_NSS]) begin
                    n.cnt = 32'h0000_0000;
                end else if (s.cnt >= WAKE_LAST) begin
                    n.state = hwc_pkg::ST_READY;
                    n.cnt = 32'h0000_0000;
                end else begin
                    n.cnt = s.cnt + 32'h0000_0001;
                end
            end
            default: begin
                n.state = hwc_pkg::ST_CALIB;
                n.cnt = 32'h0000_0000;
            end
        endcase

        // image state is not part of the context that a restart discards
        keep_ok = n.fw_ok;
        keep_acc = n.fw_acc;
        if (restart) begin
            n = TOP_RST;
            n.fw_ok = keep_ok;
            n.fw_acc = keep_acc;
        end

        n.busy = (n.state != hwc_pkg::ST_READY);
        n.miso = miso_data;
        n.miso_oe = !mfp_i[`HWC_PIN_NSS];
        n.irq = ir.req;

        if (hready) begin
            n.a_valid = hsel && htrans[1];
            n.a_write = hwrite && (hsize == 3'b010);
            n.a_addr = haddr[7:0];
        end
        // read data comes from the next state so a read right after a write sees it
        if (hsel && hready && htrans[1] && !hwrite) begin
            n.hrdata = 32'h0000_0000;
            case (haddr[7:0])
                `HWC_OFF_IRQ_STAT: n.hrdata[N_IRQ-1:0] = ir.status_nxt;
                `HWC_OFF_IRQ_EN: n.hrdata[N_IRQ-1:0] = ir.en_nxt;
                `HWC_OFF_SLEEP: begin
                    n.hrdata[`HWC_SLP_NSS_BIT] = n.wake_nss;
                    n.hrdata[`HWC_SLP_TMR_BIT] = n.wake_tmr;
                end
                `HWC_OFF_SLP_TMO: n.hrdata = n.tmo;
                `HWC_OFF_STATE: begin
                    n.hrdata[3:0] = n.state;
                    n.hrdata[`HWC_STATE_BUSY_BIT] = n.busy;
                    n.hrdata[`HWC_STATE_FWOK_BIT] = n.fw_ok;
                end
                `HWC_OFF_RF_MODE: n.hrdata[MW-1:0] = n.rf_mode;
                `HWC_OFF_RFSW_EN: n.hrdata[N_RF-1:0] = n.rfsw_en;
                `HWC_OFF_RFSW_POL: begin
                    for (int m = 0; m < MODES; m++) begin
                        n.hrdata[m*`HWC_POL_STRIDE +: N_RF] = n.rfsw_pol[m];
                    end
                end
                `HWC_OFF_FW_DATA: n.hrdata = n.fw_acc;
                default: n.hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= TOP_RST;
        end else begin
            s <= n;
        end
    end

    // fixed pin map: outputs busy, miso, irq and rf lines; select, clock, mosi are inputs
    always_comb begin
        mfp_o = '0;
        mfp_oe = '0;
        mfp_o[`HWC_PIN_BUSY] = s.busy;
        mfp_oe[`HWC_PIN_BUSY] = 1'b1;
        mfp_o[`HWC_PIN_MISO] = s.miso;
        mfp_oe[`HWC_PIN_MISO] = s.miso_oe;
        mfp_o[`HWC_PIN_IRQ] = s.irq;
        mfp_oe[`HWC_PIN_IRQ] = 1'b1;
        for (int i = 0; i < N_RF; i++) begin
            mfp_o[RF_PIN[i]] = rf_o[i];
            mfp_oe[RF_PIN[i]] = rf_oe[i];
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.rdy;
    assign hresp = 1'b0;
    assign fw_exec_ok = s.fw_ok;

    nss_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.state == hwc_pkg::ST_SLEEP && s.wake_nss && nss_fall && !restart)
        |=> s.state == hwc_pkg::ST_WAKE ##1 s.busy)
        else $error("select falling edge did not end sleep");
    timer_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.state == hwc_pkg::ST_SLEEP && s.wake_tmr && tmr_due && !restart)
        |=> s.state == hwc_pkg::ST_WAKE)
        else $error("sleep timer expiry did not end sleep");
    busy_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.state == hwc_pkg::ST_WAKE && !mfp_i[`HWC_PIN_NSS] && !restart)
        |=> mfp_o[`HWC_PIN_BUSY] [*2])
        else $error("busy fell before the device was ready");
    pin_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mfp_oe[`HWC_PIN_BUSY] && mfp_oe[`HWC_PIN_IRQ] && !mfp_oe[`HWC_PIN_NSS]
        && !mfp_oe[`HWC_PIN_SCK] && !mfp_oe[`HWC_PIN_MOSI] && !mfp_oe[`HWC_PIN_SPARE])
        else $error("pin direction breaks the fixed map");
    irq_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (mfp_o[`HWC_PIN_IRQ] == $past(ir.req)))
        else $error("request pin does not follow the gated flags");
    restart_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        restart |=> (s.state == hwc_pkg::ST_CALIB) && (s.rfsw_en == '0) && s.busy
        ##1 (mfp_oe[10] == 1'b0))
        else $error("restart pin pulse did not restart and recalibrate");
    fw_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s.a_addr == `HWC_OFF_FW_CTRL && hwdata[`HWC_FW_DONE_BIT]
        && !hwdata[`HWC_FW_START_BIT] && s.fw_acc != `HWC_FW_KEY) |=> !fw_exec_ok)
        else $error("unauthenticated image allowed to run");
endmodule

// file: testbench/hwc_host_model.sv
// host-side model: drives select, serial clock, data line and restart pin
module hwc_host_model (
    input wire logic hclk,
    output logic sel_n,
    output logic sck,
    output logic mosi,
    output logic restart_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        restart_n = 1'b1;
    end
    // no frames are sent, so the serial clock stands still; data never rests on a stale level
    always @(posedge hclk) begin
        mosi <= ~mosi;
    end
    // select low for cyc cycles then high; the caller waits for busy to fall
    task automatic wake(input int cyc);
        @(posedge hclk);
        sel_n <= 1'b0;
        repeat (cyc) @(posedge hclk);
        sel_n <= 1'b1;
    endtask
    task automatic restart(input int cyc);
        @(posedge hclk);
        restart_n <= 1'b0;
        repeat (cyc) @(posedge hclk);
        restart_n <= 1'b1;
    endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the host control block
`include "hwc_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // short calibration and wake counts keep the run brief
    localparam int CAL = 8;
    localparam int WK = 2;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [11:0] mfp_i;
    logic [11:0] mfp_o;
    logic [11:0] mfp_oe;
    logic [11:0] pin_rest = 12'h0;
    logic sel_n;
    logic sck;
    logic mosi;
    logic restart_n;
    logic [23:0] irq_evt = 24'h0;
    logic miso_data = 1'b0;
    logic fw_exec_ok;
    int err_total = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [31:0] acc;
    logic [31:0] x;
    logic [4:0] en;
    int i;
    logic [7:0] rw_off [5] = '{`HWC_OFF_IRQ_EN, `HWC_OFF_SLP_TMO, `HWC_OFF_RF_MODE,
        `HWC_OFF_RFSW_EN, `HWC_OFF_RFSW_POL};
    logic [31:0] rw_mask [5] = '{32'h00FF_FFFF, 32'hFFFF_FFFF, 32'h0000_0003, 32'h0000_001F,
        32'h1F1F_1F1F};

    always #25 hclk = ~hclk;
    assign mfp_i = {pin_rest[11:4], mosi, sck, sel_n, pin_rest[0]};

    hwc_top #(.CAL_CYC(CAL), .WAKE_CYC(WK)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mfp_i(mfp_i),
        .mfp_o(mfp_o), .mfp_oe(mfp_oe), .hard_restart_n(restart_n), .irq_evt(irq_evt),
        .miso_data(miso_data), .fw_exec_ok(fw_exec_ok)
    );
    hwc_host_model host (.hclk(hclk), .sel_n(sel_n), .sck(sck), .mosi(mosi),
        .restart_n(restart_n));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // outputs are looked at just after the edge, once its updates have landed
    task automatic tick();
        @(posedge hclk);
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) tick();
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        check("hready wait", {31'h0, hreadyout}, 32'h1);
        if (hreadyout !== 1'b1) print_verdict();
    endtask
    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_busy_low(input int lim);
        int n;
        n = 0;
        while (mfp_o[0] !== 1'b0 && n < lim) begin
            tick();
            n++;
        end
        check("busy fall", {31'h0, mfp_o[0]}, 32'h0);
        if (mfp_o[0] !== 1'b0) print_verdict();
    endtask
    function automatic logic [11:0] rf_pins(input logic [4:0] v);
        return {1'b0, v[4], 1'b0, v[3:0], 5'h0};
    endfunction
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb_rd(a, v);
        check(name, v, exp);
    endtask

    initial begin
        void'($urandom(32'h581f_779f));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        tick();
        check("busy at reset", {31'h0, mfp_o[0]}, 32'h1);
        check("rf oe at reset", {20'h0, mfp_oe & 12'h5E0}, 32'h0);
        check("fixed oe", {20'h0, mfp_oe & 12'hA0F}, 32'h201);
        check("irq at reset", {31'h0, mfp_o[9]}, 32'h0);
        check("fw ok at reset", {31'h0, fw_exec_ok}, 32'h0);
        rd_chk("state calib", `HWC_OFF_STATE, 32'h11);
        wait_busy_low(CAL + 4);
        rd_chk("state ready", `HWC_OFF_STATE, 32'h2);
        $display("test reset done");

        pin_rest <= 12'(($urandom));
        for (i = 0; i < 5; i++) begin
            x = $urandom;
            ahb_wr(rw_off[i], x);
            rd_chk("rw register", rw_off[i], x & rw_mask[i]);
        end
        ahb_wr(`HWC_OFF_SLP_TMO, 32'h0);
        rd_chk("slp tmo", `HWC_OFF_SLP_TMO, 32'h0) ;
        ahb_wr(8'h40, $urandom);
        rd_chk("unmapped", 8'h40, 32'h0);
        ahb_wr(`HWC_OFF_STATE, 32'hFFFF_FFFF);
        rd_chk("state ro", `HWC_OFF_STATE, 32'h2);
        ahb_wr(`HWC_OFF_RF_MODE, 32'h0);
        hsize <= 3'h0;
        ahb_wr(`HWC_OFF_RF_MODE, 32'h3);
        hsize <= 3'h2;
        rd_chk("byte write", `HWC_OFF_RF_MODE, 32'h0);
        $display("test registers done");

        x = $urandom & 32'h00FF_FFFF;
        ahb_wr(`HWC_OFF_IRQ_EN, x);
        rd_chk("irq enable", `HWC_OFF_IRQ_EN, x);
        for (i = 0; i < 24; i++) begin
            irq_evt <= 24'h1 << i;
            tick();
            irq_evt <= 24'h0;
            cyc(3);
            check("irq pin", {31'h0, mfp_o[9]}, {31'h0, x[i]});
            ahb_wr(`HWC_OFF_IRQ_STAT, 32'h0);
            rd_chk("irq flag", `HWC_OFF_IRQ_STAT, 32'h1 << i);
            ahb_wr(`HWC_OFF_IRQ_STAT, 32'h1 << i);
            rd_chk("irq cleared", `HWC_OFF_IRQ_STAT, 32'h0);
            check("irq pin off", {31'h0, mfp_o[9]}, 32'h0);
        end
        // event sampled at the same edge as the clear of its bit
        fork
            ahb_wr(`HWC_OFF_IRQ_STAT, 32'h20);
            begin
                tick();
                irq_evt <= 24'h20;
                tick();
                irq_evt <= 24'h0;
            end
        join
        rd_chk("set beats clear", `HWC_OFF_IRQ_STAT, 32'h20);
        ahb_wr(`HWC_OFF_IRQ_STAT, 32'h20);
        $display("test interrupts done");

        for (i = 0; i < 8; i++) begin
            en = (i == 0) ? 5'h1F : 5'(($urandom));
            x = $urandom;
            ahb_wr(`HWC_OFF_RFSW_EN, {27'h0, en});
            ahb_wr(`HWC_OFF_RFSW_POL, x & 32'h1F1F_1F1F);
            ahb_wr(`HWC_OFF_RF_MODE, i % 4);
            cyc(2);
            rd = {20'h0, rf_pins(en & x[(i % 4) * 8 +: 5])};
            check("rf level", {20'h0, mfp_o & 12'h5E0}, rd);
            check("rf oe", {20'h0, mfp_oe & 12'h5E0}, {20'h0, rf_pins(en)});
        end
        $display("test rf switch done");

        ahb_wr(`HWC_OFF_SLEEP, 32'h3);
        cyc(2);
        rd_chk("asleep", `HWC_OFF_STATE, 32'h14);
        fork
            host.wake(2000);
            begin
                cyc(10);
                rd_chk("waking", `HWC_OFF_STATE, 32'h18);
                check("miso oe", {31'h0, mfp_oe[4]}, 32'h1);
                for (i = 0; i < 6; i++) begin
                    x[0] = 1'(($urandom));
                    miso_data <= x[0];
                    tick();
                    check("miso out", {31'h0, mfp_o[4]}, {31'h0, x[0]});
                end
            end
        join
        wait_busy_low(WK + 6);
        rd_chk("woken", `HWC_OFF_STATE, 32'h2);
        ahb_wr(`HWC_OFF_SLP_TMO, 32'd20);
        ahb_wr(`HWC_OFF_SLEEP, 32'h5);
        cyc(10);
        check("timer pending", {31'h0, mfp_o[0]}, 32'h1);
        wait_busy_low(20 + WK + 10);
        ahb_wr(`HWC_OFF_SLEEP, 32'h3);
        cyc(40);
        rd_chk("timer masked", `HWC_OFF_STATE, 32'h14);
        host.wake(2000);
        wait_busy_low(WK + 6);
        $display("test sleep done");

        ahb_wr(`HWC_OFF_FW_CTRL, 32'h1);
        acc = 32'h0;
        for (i = 0; i < 4; i++) begin
            x = $urandom;
            ahb_wr(`HWC_OFF_FW_DATA, x);
            acc = {acc[30:0], acc[31]} ^ x;
        end
        rd_chk("fw acc", `HWC_OFF_FW_DATA, acc);
        ahb_wr(`HWC_OFF_FW_CTRL, 32'h2);
        tick();
        check("fw reject", {31'h0, fw_exec_ok}, {31'h0, acc == `HWC_FW_KEY});
        ahb_wr(`HWC_OFF_FW_DATA, {acc[30:0], acc[31]} ^ `HWC_FW_KEY);
        ahb_wr(`HWC_OFF_FW_CTRL, 32'h2);
        tick();
        check("fw accept", {31'h0, fw_exec_ok}, 32'h1);
        $display("test firmware done");

        ahb_wr(`HWC_OFF_IRQ_EN, 32'h00FF_FFFF);
        ahb_wr(`HWC_OFF_RFSW_EN, 32'h1F);
        host.restart(100);
        cyc(4);
        rd_chk("short restart", `HWC_OFF_IRQ_EN, 32'h00FF_FFFF);
        host.restart(`HWC_RST_MIN_CYC + 50);
        cyc(4);
        check("restart busy", {31'h0, mfp_o[0]}, 32'h1);
        check("restart rf oe", {20'h0, mfp_oe & 12'h5E0}, 32'h0);
        ahb_wr(`HWC_OFF_SLEEP, 32'h3);
        rd_chk("restart irq en", `HWC_OFF_IRQ_EN, 32'h0);
        wait_busy_low(CAL + 8);
        rd_chk("no sleep in calib", `HWC_OFF_STATE, 32'h22);
        check("fw ok kept", {31'h0, fw_exec_ok}, 32'h1);
        $display("test restart done");
        print_verdict();
    end
endmodule
